// ---- sscu_core.sv ----
// System stack mapping, bound traps, user stack pointers and call/return sequencer
`timescale 1ns/1ps
`default_nettype none
`include "sscu_regs.svh"

module sscu_core (
    input wire logic clk,
    input wire logic rst,
    input wire logic req_valid,
    output logic req_ready,
    input wire sscu_pkg::sscu_req_t req,
    input wire logic [15:0] ip_in,
    input wire logic [15:0] csp_in,
    input wire logic [2:0] stack_size_code,
    input wire logic ovb_wr,
    input wire logic [15:0] ovb_wdata,
    input wire logic unb_wr,
    input wire logic [15:0] unb_wdata,
    output logic [15:0] stack_pointer,
    output logic [15:0] overflow_bound,
    output logic [15:0] underflow_bound,
    output logic [15:0] bank_base_pointer,
    output logic [15:0] phys_addr,
    output var sscu_pkg::sscu_mem_t mem,
    input wire logic [15:0] mem_rdata,
    output logic overflow_trap,
    output logic underflow_trap,
    output logic branch,
    output logic [15:0] branch_ip,
    output logic [15:0] branch_csp,
    output logic operand_we,
    output logic [15:0] operand_wdata,
    input wire logic ua_valid,
    input wire sscu_pkg::sscu_umode_t ua_mode,
    input wire logic [3:0] ua_reg,
    input wire logic ua_byte,
    input wire logic [15:0] ua_ptr,
    output logic ua_ok,
    output logic [15:0] ua_addr,
    output logic [15:0] ua_new_ptr,
    output logic [15:0] bank_reg_addr,
    input wire logic [3:0] bank_reg_sel
);
    typedef enum {ST_IDLE, ST_PUSH1, ST_PUSH2, ST_POP1, ST_POP2} sscu_state_t;

    sscu_state_t state_ff, nxt_state;
    sscu_pkg::sscu_req_t cur_ff, nxt_cur;
    logic [15:0] sp_ff, nxt_sp;
    logic [15:0] ovb_ff, nxt_ovb;
    logic [15:0] unb_ff, nxt_unb;
    logic [15:0] cp_ff, nxt_cp;
    logic [15:0] pop_ip_ff, nxt_pop_ip;
    logic ov_ff, nxt_ov;
    logic un_ff, nxt_un;
    logic br_ff, nxt_br;
    logic [15:0] bip_ff, nxt_bip;
    logic [15:0] bcsp_ff, nxt_bcsp;
    logic opwe_ff, nxt_opwe;
    logic [15:0] opwd_ff, nxt_opwd;
    logic [15:0] sig_mask;
    logic [15:0] dec_sp;
    logic [15:0] inc_sp;
    logic [15:0] push_addr;

    // Physical stack address mapping
    always_comb begin
        unique case (stack_size_code)
            `SSCU_SZ_256: sig_mask = 16'h01ff;
            `SSCU_SZ_128: sig_mask = 16'h00ff;
            `SSCU_SZ_64: sig_mask = 16'h007f;
            `SSCU_SZ_32: sig_mask = 16'h003f;
            `SSCU_SZ_512: sig_mask = 16'h03ff;
            `SSCU_SZ_LINEAR: sig_mask = 16'h0fff;
            // Reserved codes: treat as the reset size
            default: sig_mask = 16'h01ff;
        endcase
        // Low bits plus top-of-area bits gives the wrap
        phys_addr = (stack_size_code == `SSCU_SZ_LINEAR) ? sp_ff
            : (sp_ff & sig_mask) | (`SSCU_AREA_TOP & ~sig_mask);
        phys_addr[0] = 1'b0;
    end

    // Pointer stays inside the 4 KB virtual area, bit 0 fixed
    assign dec_sp = {4'hf, sp_ff[11:1] - 11'h001, 1'b0};
    assign inc_sp = {4'hf, sp_ff[11:1] + 11'h001, 1'b0};
    // Push is pre-decrement: the word lands at the new pointer's address
    assign push_addr = (stack_size_code == `SSCU_SZ_LINEAR) ? dec_sp
        : (dec_sp & sig_mask) | (`SSCU_AREA_TOP & ~sig_mask);

    assign req_ready = (state_ff == ST_IDLE);

    always_comb begin
        nxt_state = state_ff;
        nxt_cur = cur_ff;
        nxt_sp = sp_ff;
        nxt_cp = cp_ff;
        nxt_pop_ip = pop_ip_ff;
        nxt_ov = 1'b0;
        nxt_un = 1'b0;
        nxt_br = 1'b0;
        nxt_bip = bip_ff;
        nxt_bcsp = bcsp_ff;
        nxt_opwe = 1'b0;
        nxt_opwd = opwd_ff;
        nxt_ovb = ovb_wr ? ovb_wdata : ovb_ff;
        nxt_unb = unb_wr ? unb_wdata : unb_ff;
        mem = '0;
        unique case (state_ff)
            ST_IDLE: begin
                if (req_valid) begin
                    nxt_cur = req;
                    unique case (req.op)
                        sscu_pkg::SSCU_OP_NONE: nxt_state = ST_IDLE;
                        sscu_pkg::SSCU_OP_MOV_SP:
                            nxt_sp = {4'hf, req.operand[11:1], 1'b0};
                        sscu_pkg::SSCU_OP_SUB_SP: begin
                            nxt_sp = {4'hf, sp_ff[11:1] - req.operand[11:1], 1'b0};
                            nxt_ov = nxt_sp < ovb_ff;
                        end
                        sscu_pkg::SSCU_OP_ADD_SP: begin
                            nxt_sp = {4'hf, sp_ff[11:1] + req.operand[11:1], 1'b0};
                            nxt_un = nxt_sp > unb_ff;
                        end
                        sscu_pkg::SSCU_OP_CALL: begin
                            // Untaken conditional call does nothing
                            if (req.cond_true || req.kind == sscu_pkg::SSCU_CALL_REL) begin
                                nxt_state = ST_PUSH2;
                            end
                        end
                        sscu_pkg::SSCU_OP_PUSH, sscu_pkg::SSCU_OP_PUSH_AND_CALL_INSTR,
                        sscu_pkg::SSCU_OP_CALLS, sscu_pkg::SSCU_OP_CONTEXT_SWITCH_INSTR:
                            nxt_state = ST_PUSH1;
                        sscu_pkg::SSCU_OP_POP, sscu_pkg::SSCU_OP_RET, sscu_pkg::SSCU_OP_RETURN_AND_POP_INSTR,
                        sscu_pkg::SSCU_OP_INTER_SEGMENT_RETURN, sscu_pkg::SSCU_OP_POP_CP:
                            nxt_state = ST_POP1;
                        default: nxt_state = ST_IDLE;
                    endcase
                end
            end
            ST_PUSH1: begin
                // First word: operand, segment pointer or old bank pointer
                mem.addr = push_addr;
                mem.wr = 1'b1;
                unique case (cur_ff.op)
                    sscu_pkg::SSCU_OP_CALLS: mem.wdata = csp_in;
                    sscu_pkg::SSCU_OP_CONTEXT_SWITCH_INSTR: mem.wdata = cp_ff;
                    default: mem.wdata = cur_ff.operand;
                endcase
                nxt_sp = dec_sp;
                nxt_ov = dec_sp < ovb_ff;
                if (cur_ff.op == sscu_pkg::SSCU_OP_CONTEXT_SWITCH_INSTR) begin
                    nxt_cp = cur_ff.operand;
                end
                if (cur_ff.op == sscu_pkg::SSCU_OP_PUSH_AND_CALL_INSTR ||
                    cur_ff.op == sscu_pkg::SSCU_OP_CALLS) begin
                    nxt_state = ST_PUSH2;
                end else begin
                    nxt_state = ST_IDLE;
                end
            end
            ST_PUSH2: begin
                // Return address goes last so the return pops it first
                mem.addr = push_addr;
                mem.wr = 1'b1;
                mem.wdata = ip_in;
                nxt_sp = dec_sp;
                nxt_ov = dec_sp < ovb_ff;
                nxt_br = 1'b1;
                nxt_bip = cur_ff.target;
                nxt_bcsp = (cur_ff.op == sscu_pkg::SSCU_OP_CALLS) ? cur_ff.target_seg
                    : csp_in;
                nxt_state = ST_IDLE;
            end
            ST_POP1: begin
                mem.addr = phys_addr;
                mem.rd = 1'b1;
                nxt_sp = inc_sp;
                nxt_un = inc_sp > unb_ff;
                nxt_state = ST_IDLE;
                unique case (cur_ff.op)
                    sscu_pkg::SSCU_OP_RET: begin
                        nxt_br = 1'b1;
                        nxt_bip = mem_rdata;
                        nxt_bcsp = csp_in;
                    end
                    sscu_pkg::SSCU_OP_RETURN_AND_POP_INSTR, sscu_pkg::SSCU_OP_INTER_SEGMENT_RETURN: begin
                        nxt_pop_ip = mem_rdata;
                        nxt_state = ST_POP2;
                    end
                    sscu_pkg::SSCU_OP_POP_CP: nxt_cp = mem_rdata;
                    default: begin
                        nxt_opwe = 1'b1;
                        nxt_opwd = mem_rdata;
                    end
                endcase
            end
            ST_POP2: begin
                mem.addr = phys_addr;
                mem.rd = 1'b1;
                nxt_sp = inc_sp;
                nxt_un = inc_sp > unb_ff;
                nxt_br = 1'b1;
                nxt_bip = pop_ip_ff;
                if (cur_ff.op == sscu_pkg::SSCU_OP_INTER_SEGMENT_RETURN) begin
                    nxt_bcsp = mem_rdata;
                end else begin
                    nxt_bcsp = csp_in;
                    nxt_opwe = 1'b1;
                    nxt_opwd = mem_rdata;
                end
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_ff <= ST_IDLE;
            cur_ff <= '0;
            sp_ff <= `SSCU_SP_RST;
            ovb_ff <= `SSCU_OVB_RST;
            unb_ff <= `SSCU_UNB_RST;
            cp_ff <= 16'h0000;
            pop_ip_ff <= 16'h0000;
            ov_ff <= 1'b0;
            un_ff <= 1'b0;
            br_ff <= 1'b0;
            bip_ff <= 16'h0000;
            bcsp_ff <= 16'h0000;
            opwe_ff <= 1'b0;
            opwd_ff <= 16'h0000;
        end else begin
            state_ff <= nxt_state;
            cur_ff <= nxt_cur;
            sp_ff <= nxt_sp;
            ovb_ff <= nxt_ovb;
            unb_ff <= nxt_unb;
            cp_ff <= nxt_cp;
            pop_ip_ff <= nxt_pop_ip;
            ov_ff <= nxt_ov;
            un_ff <= nxt_un;
            br_ff <= nxt_br;
            bip_ff <= nxt_bip;
            bcsp_ff <= nxt_bcsp;
            opwe_ff <= nxt_opwe;
            opwd_ff <= nxt_opwd;
        end
    end

    assign stack_pointer = sp_ff;
    assign overflow_bound = ovb_ff;
    assign underflow_bound = unb_ff;
    assign bank_base_pointer = cp_ff;
    assign overflow_trap = ov_ff;
    assign underflow_trap = un_ff;
    assign branch = br_ff;
    assign branch_ip = bip_ff;
    assign branch_csp = bcsp_ff;
    assign operand_we = opwe_ff;
    assign operand_wdata = opwd_ff;

    // User stacks: no bound checks here
    logic [15:0] ua_step;
    assign ua_step = ua_byte ? 16'h0001 : `SSCU_WORD;
    always_comb begin
        ua_ok = ua_valid;
        ua_addr = ua_ptr;
        ua_new_ptr = ua_ptr + ua_step;
        unique case (ua_mode)
            sscu_pkg::SSCU_UA_PREDEC: begin
                ua_addr = ua_ptr - ua_step;
                ua_new_ptr = ua_ptr - ua_step;
            end
            sscu_pkg::SSCU_UA_POSTINC_IDX: ua_ok = ua_valid && (ua_reg < 4'h4);
            sscu_pkg::SSCU_UA_POSTINC: ua_ok = ua_valid;
            default: ua_ok = 1'b0;
        endcase
    end

    // Bank register word address, 16 registers per bank
    assign bank_reg_addr = cp_ff + {11'h000, bank_reg_sel, 1'b0};

    sequence s_push_word;
        mem.wr && (state_ff == ST_PUSH1 || state_ff == ST_PUSH2);
    endsequence

    a_sp_move_quiet: assert property (@(posedge clk) disable iff (rst)
        (state_ff == ST_IDLE && req_valid && req.op == sscu_pkg::SSCU_OP_MOV_SP)
        |=> !overflow_trap && !underflow_trap)
        else $error("move into pointer raised a trap");
    a_sp_bit_zero: assert property (@(posedge clk) disable iff (rst)
        stack_pointer[0] == 1'b0) else $error("pointer bit 0 set");
    a_ov_trap_cause: assert property (@(posedge clk) disable iff (rst)
        s_push_word |=> (overflow_trap == (stack_pointer < overflow_bound)) || $past(ovb_wr))
        else $error("overflow trap mismatch");
    a_linear_map: assert property (@(posedge clk) disable iff (rst)
        stack_size_code == `SSCU_SZ_LINEAR |-> phys_addr == stack_pointer)
        else $error("linear address altered");
    a_circ_top: assert property (@(posedge clk) disable iff (rst)
        (stack_size_code == `SSCU_SZ_256 && stack_pointer[8:1] == 8'hff) |->
        phys_addr == `SSCU_AREA_TOP) else $error("wrap not to top");
    a_calls_two: assert property (@(posedge clk) disable iff (rst)
        (state_ff == ST_PUSH1 && cur_ff.op == sscu_pkg::SSCU_OP_CALLS) |->
        mem.wdata == csp_in ##1 s_push_word ##1 branch)
        else $error("segment call sequence");
    a_cond_call: assert property (@(posedge clk) disable iff (rst)
        (state_ff == ST_IDLE && req_valid && req.op == sscu_pkg::SSCU_OP_CALL &&
        !req.cond_true && req.kind != sscu_pkg::SSCU_CALL_REL) |=> state_ff == ST_IDLE)
        else $error("untaken call pushed");
    a_idx_reg: assert property (@(posedge clk) disable iff (rst)
        (ua_mode == sscu_pkg::SSCU_UA_POSTINC_IDX && ua_reg > 4'h3) |-> !ua_ok)
        else $error("index pointer above R3");
endmodule
`default_nettype wire

// ---- sscu_regs.svh ----
// Offsets, reset values and field constants of the stack call unit
`ifndef SSCU_REGS_SVH
`define SSCU_REGS_SVH

`define SSCU_SP_RST 16'hfc00
`define SSCU_OVB_RST 16'hfa00
`define SSCU_UNB_RST 16'hfc00
`define SSCU_SZ_RST 3'h0
`define SSCU_AREA_TOP 16'hfbfe
`define SSCU_VIRT_BASE 16'hf000
`define SSCU_SZ_256 3'h0
`define SSCU_SZ_128 3'h1
`define SSCU_SZ_64 3'h2
`define SSCU_SZ_32 3'h3
`define SSCU_SZ_512 3'h4
`define SSCU_SZ_LINEAR 3'h7
`define SSCU_BANK_REGS 5'h10
`define SSCU_WORD 16'h0002

`endif

// ---- sscu_pkg.sv ----
// Types of the stack call unit
package sscu_pkg;
    typedef enum logic [3:0] {
        SSCU_OP_NONE,
        SSCU_OP_PUSH,
        SSCU_OP_POP,
        SSCU_OP_ADD_SP,
        SSCU_OP_SUB_SP,
        SSCU_OP_MOV_SP,
        SSCU_OP_CALL,
        SSCU_OP_RET,
        SSCU_OP_PUSH_AND_CALL_INSTR,
        SSCU_OP_RETURN_AND_POP_INSTR,
        SSCU_OP_CALLS,
        SSCU_OP_INTER_SEGMENT_RETURN,
        SSCU_OP_CONTEXT_SWITCH_INSTR,
        SSCU_OP_POP_CP
    } sscu_op_t;

    typedef enum logic [1:0] {
        SSCU_CALL_ABS,
        SSCU_CALL_IND,
        SSCU_CALL_REL
    } sscu_call_kind_t;

    typedef struct packed {
        sscu_op_t op;
        sscu_call_kind_t kind;
        logic cond_true;
        logic [15:0] operand;
        logic [15:0] target;
        logic [15:0] target_seg;
    } sscu_req_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } sscu_mem_t;

    typedef enum logic [1:0] {
        SSCU_UA_PREDEC,
        SSCU_UA_POSTINC_IDX,
        SSCU_UA_POSTINC
    } sscu_umode_t;
endpackage

// ---- sscu_ram_model.sv ----
// Internal RAM model answering the stack unit's word accesses
`timescale 1ns/1ps
`default_nettype none
module sscu_ram_model (
    input wire logic clk,
    input wire sscu_pkg::sscu_mem_t mem,
    output logic [15:0] mem_rdata
);
    logic [15:0] ram [0:32767];
    logic [15:0] last_ff = 16'h0000;

    // Idle bus shows inverted last data so a stale word never passes for a read
    assign mem_rdata = mem.rd ? ram[mem.addr[15:1]] : ~last_ff;

    always @(posedge clk) begin
        if (mem.wr) begin
            ram[mem.addr[15:1]] <= mem.wdata;
        end
        if (mem.rd) begin
            last_ff <= ram[mem.addr[15:1]];
        end
    end
endmodule
`default_nettype wire

// ---- testbench.sv ----
// Self-checking bench of the stack call unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk, rst, req_valid, req_ready, ovb_wr, unb_wr, ua_valid, ua_byte, ua_ok;
    logic overflow_trap, underflow_trap, branch, operand_we;
    sscu_pkg::sscu_req_t req;
    sscu_pkg::sscu_mem_t mem;
    sscu_pkg::sscu_umode_t ua_mode;
    logic [2:0] stack_size_code;
    logic [3:0] ua_reg, bank_reg_sel;
    logic [15:0] ip_in, csp_in, ovb_wdata, unb_wdata, stack_pointer, overflow_bound;
    logic [15:0] underflow_bound, bank_base_pointer, phys_addr, mem_rdata, branch_ip;
    logic [15:0] branch_csp, operand_wdata, ua_ptr, ua_addr, ua_new_ptr, bank_reg_addr;
    logic [15:0] wqa[$], wqd[$], rq[$], ewa[$], ewd[$], era[$], sh[logic [15:0]];
    logic [15:0] nbr, nov, nun, nwe, gbip, gbcsp, gowd, exp_sp, exp_cp, exp_ov, exp_un;
    int failures, cmp_count, cyc;

    sscu_core i_dut (.clk(clk), .rst(rst), .req_valid(req_valid), .req_ready(req_ready),
        .req(req), .ip_in(ip_in), .csp_in(csp_in), .stack_size_code(stack_size_code),
        .ovb_wr(ovb_wr), .ovb_wdata(ovb_wdata), .unb_wr(unb_wr), .unb_wdata(unb_wdata),
        .stack_pointer(stack_pointer), .overflow_bound(overflow_bound),
        .underflow_bound(underflow_bound), .bank_base_pointer(bank_base_pointer),
        .phys_addr(phys_addr), .mem(mem), .mem_rdata(mem_rdata),
        .overflow_trap(overflow_trap), .underflow_trap(underflow_trap), .branch(branch),
        .branch_ip(branch_ip), .branch_csp(branch_csp), .operand_we(operand_we),
        .operand_wdata(operand_wdata), .ua_valid(ua_valid), .ua_mode(ua_mode),
        .ua_reg(ua_reg), .ua_byte(ua_byte), .ua_ptr(ua_ptr), .ua_ok(ua_ok),
        .ua_addr(ua_addr), .ua_new_ptr(ua_new_ptr), .bank_reg_addr(bank_reg_addr),
        .bank_reg_sel(bank_reg_sel));
    sscu_ram_model i_ram (.clk(clk), .mem(mem), .mem_rdata(mem_rdata));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic wrap_up();
        if (failures == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    always @(posedge clk) begin
        if (mem.wr) begin
            wqa.push_back(mem.addr);
            wqd.push_back(mem.wdata);
        end
        if (mem.rd) rq.push_back(mem.addr);
        if (branch) begin
            nbr++;
            gbip = branch_ip;
            gbcsp = branch_csp;
        end
        nov += 16'(overflow_trap);
        nun += 16'(underflow_trap);
        if (operand_we) begin
            nwe++;
            gowd = operand_wdata;
        end
        cyc++;
        // Whole run needs well under 3000 cycles
        if (cyc == 20000) begin
            failures++;
            wrap_up();
        end
    end

    task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    function automatic logic [15:0] map_addr(logic [15:0] sp);
        logic [15:0] m;
        case (stack_size_code)
            3'h1: m = 16'h00ff;
            3'h2: m = 16'h007f;
            3'h3: m = 16'h003f;
            3'h4: m = 16'h03ff;
            3'h7: return sp;
            default: m = 16'h01ff;
        endcase
        return (16'hfbfe & ~m) | (sp & m);
    endfunction

    function automatic void push_e(logic [15:0] v);
        exp_sp -= 16'h0002;
        ewa.push_back(map_addr(exp_sp));
        ewd.push_back(v);
        sh[map_addr(exp_sp)] = v;
    endfunction

    function automatic logic [15:0] pop_e();
        logic [15:0] a;
        a = map_addr(exp_sp);
        era.push_back(a);
        exp_sp += 16'h0002;
        return sh[a];
    endfunction

    task automatic do_op(sscu_pkg::sscu_op_t op, sscu_pkg::sscu_call_kind_t k, logic c,
            logic [15:0] opd, logic [15:0] tgt, logic [15:0] seg);
        logic dec, inc, br;
        logic [15:0] bip, bcsp, owd, nw;
        int n;
        dec = 1'b0;
        inc = 1'b0;
        br = 1'b0;
        nw = 16'h0000;
        bip = tgt;
        bcsp = seg;
        owd = 16'h0000;
        ip_in = 16'($urandom);
        csp_in = 16'($urandom);
        wqa.delete();
        wqd.delete();
        rq.delete();
        ewa.delete();
        ewd.delete();
        era.delete();
        {nbr, nov, nun, nwe} = 64'h0;
        case (op)
            sscu_pkg::SSCU_OP_PUSH: begin push_e(opd); dec = 1'b1; end
            sscu_pkg::SSCU_OP_POP: begin owd = pop_e(); nw = 16'h1; inc = 1'b1; end
            sscu_pkg::SSCU_OP_ADD_SP: begin exp_sp += opd; inc = 1'b1; end
            sscu_pkg::SSCU_OP_SUB_SP: begin exp_sp -= opd; dec = 1'b1; end
            sscu_pkg::SSCU_OP_MOV_SP: exp_sp = opd & 16'hfffe;
            sscu_pkg::SSCU_OP_CALL: if (c || k == sscu_pkg::SSCU_CALL_REL) begin
                push_e(ip_in);
                {dec, br} = 2'b11;
            end
            sscu_pkg::SSCU_OP_PUSH_AND_CALL_INSTR: begin push_e(opd); push_e(ip_in); {dec, br} = 2'b11; end
            sscu_pkg::SSCU_OP_CALLS: begin push_e(csp_in); push_e(ip_in); {dec, br} = 2'b11; end
            sscu_pkg::SSCU_OP_RET: begin bip = pop_e(); {inc, br} = 2'b11; end
            sscu_pkg::SSCU_OP_RETURN_AND_POP_INSTR: begin
                bip = pop_e();
                owd = pop_e();
                nw = 16'h1;
                {inc, br} = 2'b11;
            end
            sscu_pkg::SSCU_OP_INTER_SEGMENT_RETURN: begin bip = pop_e(); bcsp = pop_e(); {inc, br} = 2'b11; end
            sscu_pkg::SSCU_OP_CONTEXT_SWITCH_INSTR: begin push_e(exp_cp); exp_cp = opd; dec = 1'b1; end
            default: begin exp_cp = pop_e(); inc = 1'b1; end
        endcase
        req = '{op, k, c, opd, tgt, seg};
        req_valid = 1'b1;
        @(posedge clk);
        #1 req_valid = 1'b0;
        chk("req_ready", 16'(ewa.size() + era.size() == 0), 16'(req_ready));
        for (n = 0; n < 50 && req_ready !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        repeat (3) @(posedge clk);
        #1;
        chk("stack_pointer", exp_sp, stack_pointer);
        chk("bank_base_pointer", exp_cp, bank_base_pointer);
        chk("write_count", 16'(ewa.size()), 16'(wqa.size()));
        chk("read_count", 16'(era.size()), 16'(rq.size()));
        foreach (ewa[i]) if (i < wqa.size()) begin
            chk("write_addr", ewa[i], wqa[i]);
            chk("write_data", ewd[i], wqd[i]);
        end
        foreach (era[i]) if (i < rq.size()) chk("read_addr", era[i], rq[i]);
        chk("branch_count", 16'(br), nbr);
        if (br) chk("branch_ip", bip, gbip);
        if (op == sscu_pkg::SSCU_OP_CALLS || op == sscu_pkg::SSCU_OP_INTER_SEGMENT_RETURN)
            chk("branch_csp", bcsp, gbcsp);
        chk("overflow_trap", 16'(dec && exp_sp < exp_ov), nov);
        chk("underflow_trap", 16'(inc && exp_sp > exp_un), nun);
        chk("operand_we", nw, nwe);
        if (nw == 16'h1) chk("operand_wdata", owd, gowd);
    endtask

    task automatic set_bounds(logic [15:0] ov, logic [15:0] un);
        {ovb_wr, unb_wr, ovb_wdata, unb_wdata} = {2'b11, ov, un};
        @(posedge clk);
        #1 {ovb_wr, unb_wr} = 2'b00;
        {exp_ov, exp_un} = {ov, un};
        chk("overflow_bound", ov, overflow_bound);
        chk("underflow_bound", un, underflow_bound);
    endtask

    initial begin
        {rst, req_valid, ovb_wr, unb_wr, ua_valid, ua_byte} = 6'b100000;
        {req, ip_in, csp_in, ovb_wdata, unb_wdata, ua_ptr} = '0;
        {stack_size_code, ua_reg, bank_reg_sel} = 11'h000;
        ua_mode = sscu_pkg::SSCU_UA_PREDEC;
        {failures, cmp_count, cyc} = 96'h0;
        {exp_sp, exp_cp, exp_ov, exp_un} = {16'hfc00, 16'h0000, 16'hfa00, 16'hfc00};
        void'($urandom(47));
        repeat (4) @(posedge clk);
        #1 rst = 1'b0;
        chk("stack_pointer", 16'hfc00, stack_pointer);
        chk("overflow_bound", 16'hfa00, overflow_bound);
        chk("underflow_bound", 16'hfc00, underflow_bound);
        chk("bank_base_pointer", 16'h0000, bank_base_pointer);
        for (int c = 0; c < 8; c++) begin
            stack_size_code = 3'(c);
            repeat (3) begin
                do_op(sscu_pkg::SSCU_OP_MOV_SP, sscu_pkg::SSCU_CALL_ABS, 1'b0,
                    {4'hf, 12'($urandom)}, 16'h0, 16'h0);
                chk("phys_addr", map_addr(exp_sp), phys_addr);
            end
        end
        // Wrap from the lowest word of a 256 word area to its top word
        stack_size_code = 3'h0;
        do_op(sscu_pkg::SSCU_OP_MOV_SP, sscu_pkg::SSCU_CALL_ABS, 1'b0, 16'hf802, 16'h0, 16'h0);
        for (int i = 0; i < 2; i++)
            do_op(sscu_pkg::SSCU_OP_PUSH, sscu_pkg::SSCU_CALL_ABS, 1'b0, 16'($urandom),
                16'h0, 16'h0);
        // Stack kept inside internal RAM below the register space
        do_op(sscu_pkg::SSCU_OP_MOV_SP, sscu_pkg::SSCU_CALL_ABS, 1'b0, 16'hfc00, 16'h0, 16'h0);
        for (int k = 0; k < 3; k++)
            for (int c = 0; c < 2; c++) begin
                do_op(sscu_pkg::SSCU_OP_CALL, sscu_pkg::sscu_call_kind_t'(k), 1'(c), 16'h0,
                    16'($urandom), 16'h0);
                if (c == 1 || k == 2)
                    do_op(sscu_pkg::SSCU_OP_RET, sscu_pkg::SSCU_CALL_ABS, 1'b0, 16'h0, 16'h0,
                        16'h0);
            end
        do_op(sscu_pkg::SSCU_OP_PUSH_AND_CALL_INSTR, sscu_pkg::SSCU_CALL_ABS, 1'b0, 16'($urandom),
            16'($urandom), 16'h0);
        do_op(sscu_pkg::SSCU_OP_RETURN_AND_POP_INSTR, sscu_pkg::SSCU_CALL_ABS, 1'b0, 16'h0, 16'h0, 16'h0);
        do_op(sscu_pkg::SSCU_OP_CALLS, sscu_pkg::SSCU_CALL_ABS, 1'b0, 16'h0, 16'($urandom),
            16'($urandom));
        do_op(sscu_pkg::SSCU_OP_INTER_SEGMENT_RETURN, sscu_pkg::SSCU_CALL_ABS, 1'b0, 16'h0, 16'h0, 16'h0);
        do_op(sscu_pkg::SSCU_OP_CONTEXT_SWITCH_INSTR, sscu_pkg::SSCU_CALL_ABS, 1'b0, 16'hf600, 16'h0, 16'h0);
        for (int s = 0; s < 16; s++) begin
            bank_reg_sel = 4'(s);
            #1 chk("bank_reg_addr", 16'hf600 + 16'(2 * s), bank_reg_addr);
            @(posedge clk);
            #1;
        end
        do_op(sscu_pkg::SSCU_OP_POP_CP, sscu_pkg::SSCU_CALL_ABS, 1'b0, 16'h0, 16'h0, 16'h0);
        // Bounds close to the pointer so the third push trips overflow and the second pop trips underflow
        set_bounds(16'hfbfc, 16'hfbfc);
        for (int i = 0; i < 3; i++)
            do_op(sscu_pkg::SSCU_OP_PUSH, sscu_pkg::SSCU_CALL_ABS, 1'b0, 16'($urandom),
                16'h0, 16'h0);
        for (int i = 0; i < 3; i++)
            do_op(sscu_pkg::SSCU_OP_POP, sscu_pkg::SSCU_CALL_ABS, 1'b0, 16'h0, 16'h0, 16'h0);
        do_op(sscu_pkg::SSCU_OP_SUB_SP, sscu_pkg::SSCU_CALL_ABS, 1'b0, 16'h000a, 16'h0, 16'h0);
        do_op(sscu_pkg::SSCU_OP_ADD_SP, sscu_pkg::SSCU_CALL_ABS, 1'b0, 16'h000a, 16'h0, 16'h0);
        do_op(sscu_pkg::SSCU_OP_MOV_SP, sscu_pkg::SSCU_CALL_ABS, 1'b0, 16'hfb00, 16'h0, 16'h0);
        nov = 16'h0;
        ua_valid = 1'b1;
        for (int m = 0; m < 3; m++)
            for (int r = 0; r < 16; r++) begin
                ua_mode = sscu_pkg::sscu_umode_t'(m);
                {ua_reg, ua_byte, ua_ptr} = {4'(r), 1'($urandom), 16'($urandom)};
                #1;
                chk("ua_ok", 16'(!(m == 1 && r > 3)), 16'(ua_ok));
                chk("ua_addr", (m == 0) ? ua_ptr - (ua_byte ? 16'h1 : 16'h2) : ua_ptr,
                    ua_addr);
                chk("ua_new_ptr", (m == 0) ? ua_ptr - (ua_byte ? 16'h1 : 16'h2)
                    : ua_ptr + (ua_byte ? 16'h1 : 16'h2), ua_new_ptr);
                @(posedge clk);
                #1;
            end
        ua_valid = 1'b0;
        chk("overflow_trap", 16'h0, nov);
        wrap_up();
    end
endmodule
`default_nettype wire
